// [verilog/hsms_params.svh]
// Purpose: Timing counts and code constants for the sample and mode sequencer
// Assumes: clk_in at 100 MHz (10 ns)
// Notes:   Internal tick is about 10 us; cycle counts are derived from times, phase counts are set directly in ticks
`ifndef HSMS_PARAMS_SVH
`define HSMS_PARAMS_SVH

`define HSMS_CLK_PERIOD_NS   10
`define HSMS_TICK_NS         10000
`define HSMS_TICK_CYCLES     (`HSMS_TICK_NS / `HSMS_CLK_PERIOD_NS)
`define HSMS_TRIG_TICKS      1
`define HSMS_AWAKE_TICKS     12
`define HSMS_UPDATE_TICKS    1
`define HSMS_EXT_CONV_TICKS  14
`define HSMS_TURBO_CONV_TICKS 16
`define HSMS_UP_RATE_HZ      24
`define HSMS_UP_PERIOD_TICKS (100000 / `HSMS_UP_RATE_HZ)
`define HSMS_SETTLE_US       1000
`define HSMS_SETTLE_CYCLES   ((`HSMS_SETTLE_US * 1000) / `HSMS_CLK_PERIOD_NS)
`define HSMS_MODE_TICKS      `HSMS_EXT_CONV_TICKS
`define HSMS_MID_CODE        8'h80
`define HSMS_CODE_W          8

`endif

// [verilog/hsms_pkg.sv]
// Purpose: Types for the sample and mode sequencer
// Assumes: Nothing beyond the params header
// Notes:   State names follow the conversion phases
package hsms_pkg;
    typedef enum logic [2:0] {
        HSMS_SLEEP,
        HSMS_TRIG,
        HSMS_AWAKE,
        HSMS_UPDATE,
        HSMS_PAD
    } hsms_state_e;

    typedef enum logic [1:0] {
        HSMS_MODE_MICRO,
        HSMS_MODE_TURBO,
        HSMS_MODE_EXT
    } hsms_mode_e;
endpackage : hsms_pkg

// [verilog/hsms_sequencer.sv]
// Purpose: Sample and mode sequencer of a linear magnetic sensor readout
// Assumes: mode_control_pin is asynchronous; sample_code_in is the converter result
// Notes:   Settle and micropower periods are parameters so simulation can shorten them
`timescale 1ns/1ps
`include "hsms_params.svh"

module hsms_sequencer
    import hsms_pkg::*;
#(
    parameter int SETTLE_CYCLES = `HSMS_SETTLE_CYCLES,
    parameter int UP_PERIOD_TICKS = `HSMS_UP_PERIOD_TICKS
) (
    // Clock and reset
    input  wire logic                     clk_in,
    input  wire logic                     nrst_in,
    // Mode control pin and its pull-down
    input  wire logic                     mode_control_pin_in,
    input  wire logic                     mode_control_pin_driven_in,
    // Converter result, signed offset from null; zero means null field
    input  wire logic [`HSMS_CODE_W-1:0]  sample_code_in,
    // Output code and status
    output logic [`HSMS_CODE_W-1:0]       out_code_out,
    output logic                          out_valid_out,
    output logic                          awake_out,
    output logic [1:0]                    mode_out
);

    // Synchroniser stages for the pin and its drive sense
    logic [1:0]        pin_sync_reg;
    logic [1:0]        drv_sync_reg;
    logic              pin_prev_reg;       // Previous synced level for edge detect
    // Tick prescaler and tick counters
    logic [15:0]       pre_reg;
    logic [15:0]       phase_reg;          // Ticks spent in current state
    logic [15:0]       sleep_reg;          // Ticks since last conversion start
    logic [4:0]        mode_ticks_reg;     // Ticks of unbroken level
    logic [31:0]       settle_reg;
    hsms_state_e       state_reg;
    hsms_state_e       state_next;
    hsms_mode_e        mode_reg;
    logic [`HSMS_CODE_W-1:0] code_reg;
    logic [`HSMS_CODE_W-1:0] held_reg;    // Sample captured at end of awake
    logic              valid_reg;
    logic              awake_reg;

    // Decoded pin level; undriven pin reads low through the pull-down
    wire pin_level   = pin_sync_reg[1] & drv_sync_reg[1];
    wire rise        = pin_level & ~pin_prev_reg;
    wire tick        = (pre_reg == 16'(`HSMS_TICK_CYCLES - 1));
    wire settled     = (settle_reg == 32'(SETTLE_CYCLES));
    wire phase_end_trig   = tick && (phase_reg == 16'(`HSMS_TRIG_TICKS - 1));
    wire phase_end_awake  = tick && (phase_reg == 16'(`HSMS_AWAKE_TICKS - 1));
    wire phase_end_update = tick && (phase_reg == 16'(`HSMS_UPDATE_TICKS - 1));
    // Turbo pads the cycle to 16 ticks with two idle ticks
    wire phase_end_pad    = tick &&
        (phase_reg == 16'(`HSMS_TURBO_CONV_TICKS - `HSMS_EXT_CONV_TICKS - 1));
    wire up_due      = (sleep_reg >= 16'(UP_PERIOD_TICKS - 1)) && tick;
    // After settle, a rising edge in sleep is an external trigger, even the one that leaves micro or turbo
    // Turbo restarts in the cycle after the pad, so the period stays 16 ticks
    wire start_conv  = settled && (
        rise ||
        (mode_reg == HSMS_MODE_TURBO) ||
        (mode_reg == HSMS_MODE_MICRO && up_due));

    // Synchronisers: first stage feeds only the second
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pin_sync_reg <= 2'h0;
            drv_sync_reg <= 2'h0;
            pin_prev_reg <= 1'b0;
        end else begin
            pin_sync_reg <= {pin_sync_reg[0], mode_control_pin_in};
            drv_sync_reg <= {drv_sync_reg[0], mode_control_pin_driven_in};
            pin_prev_reg <= pin_level;
        end
    end

    // Tick prescaler, free running
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pre_reg <= 16'h0000;
        end else if (tick) begin
            pre_reg <= 16'h0000;
        end else begin
            pre_reg <= pre_reg + 16'h0001;
        end
    end

    // Power-on settle counter
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            settle_reg <= 32'h0000_0000;
        end else if (!settled) begin
            settle_reg <= settle_reg + 32'h0000_0001;
        end
    end

    // Mode detect: a level unbroken for a full conversion picks micro or turbo
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            mode_ticks_reg <= 5'h00;
            mode_reg       <= HSMS_MODE_MICRO;
        end else if (pin_level != pin_prev_reg) begin
            // Any transition restarts the count; pulses mean external drive
            mode_ticks_reg <= 5'h00;
            if (rise) begin
                mode_reg <= HSMS_MODE_EXT;
            end
        end else if (tick) begin
            if (mode_ticks_reg == 5'(`HSMS_MODE_TICKS)) begin
                // Level held: low means micropower, high means turbo
                mode_reg <= pin_level ? HSMS_MODE_TURBO : HSMS_MODE_MICRO;
            end else begin
                mode_ticks_reg <= mode_ticks_reg + 5'h01;
            end
        end
    end

    // Ticks since last start, paces micropower mode
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sleep_reg <= 16'h0000;
        end else if (start_conv && state_reg == HSMS_SLEEP) begin
            sleep_reg <= 16'h0000;
        end else if (tick && sleep_reg != 16'hFFFF) begin
            sleep_reg <= sleep_reg + 16'h0001;
        end
    end

    // Next state of the conversion sequence
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            HSMS_SLEEP: begin
                if (start_conv) begin
                    state_next = HSMS_TRIG;
                end
            end
            HSMS_TRIG: begin
                if (phase_end_trig) begin
                    state_next = HSMS_AWAKE;
                end
            end
            HSMS_AWAKE: begin
                if (phase_end_awake) begin
                    state_next = HSMS_UPDATE;
                end
            end
            HSMS_UPDATE: begin
                if (phase_end_update) begin
                    // Turbo stretches to 16 ticks, others end at 14
                    state_next = (mode_reg == HSMS_MODE_TURBO) ? HSMS_PAD : HSMS_SLEEP;
                end
            end
            HSMS_PAD: begin
                if (phase_end_pad) begin
                    state_next = HSMS_SLEEP;
                end
            end
            default: begin
                state_next = HSMS_SLEEP;
            end
        endcase
    end

    // State register and phase tick counter
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state_reg <= HSMS_SLEEP;
            phase_reg <= 16'h0000;
        end else begin
            state_reg <= state_next;
            if (state_next != state_reg) begin
                phase_reg <= 16'h0000;
            end else if (tick) begin
                phase_reg <= phase_reg + 16'h0001;
            end
        end
    end

    // Capture at end of awake, load output in update tick, hold otherwise
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            held_reg  <= `HSMS_MID_CODE;
            code_reg  <= `HSMS_MID_CODE;
            valid_reg <= 1'b0;
        end else begin
            if (state_reg == HSMS_AWAKE && phase_end_awake) begin
                // Offset code flips MSB so zero maps to mid-scale
                held_reg <= sample_code_in ^ `HSMS_MID_CODE;
            end
            if (state_reg == HSMS_UPDATE && phase_end_update) begin
                code_reg  <= held_reg;
                valid_reg <= settled;
            end
        end
    end

    // Output flops
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            awake_reg <= 1'b0;
        end else begin
            awake_reg <= (state_next == HSMS_AWAKE);
        end
    end

    assign out_code_out  = code_reg;
    assign out_valid_out = valid_reg;
    assign awake_out     = awake_reg;
    assign mode_out      = mode_reg;

endmodule : hsms_sequencer

// [sim/hsms_seq_chk.sv]
// Purpose: Port timing checks for the sequencer
// Assumes: One tick is 1000 clocks
// Notes:   Counters stand in for long repeats
`timescale 1ns/1ps
module hsms_seq_chk #(
    parameter int SETTLE_CYCLES   = 100000,
    parameter int UP_PERIOD_TICKS = 4166
) (
    input wire logic       clk_in,
    input wire logic       nrst_in,
    input wire logic       mode_control_pin_in,
    input wire logic       mode_control_pin_driven_in,
    input wire logic [7:0] sample_code_in,
    input wire logic [7:0] out_code_out,
    input wire logic       out_valid_out,
    input wire logic       awake_out,
    input wire logic [1:0] mode_out
);
    int         awk, slp, gap, up, flt; // Spans: awake, asleep, since rise, run, floating
    logic       aw_d;                   // Awake one cycle ago
    logic [1:0] lm;                     // Mode at the last awake rise
    default clocking @(posedge clk_in); endclocking
    default disable iff (!nrst_in);
    // Span counters; all but awk saturate
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            awk  <= 0;
            slp  <= 99999;
            gap  <= 99999;
            up   <= 0;
            flt  <= 0;
            aw_d <= 1'b0;
            lm   <= 2'h3;
        end else begin
            aw_d <= awake_out;
            awk  <= awake_out ? awk + 1 : 0;
            slp  <= awake_out ? 0 : slp + int'(slp < 99999);
            gap  <= (awake_out && !aw_d) ? 1 : gap + int'(gap < 99999);
            up   <= up + int'(up < 99999999);
            flt  <= mode_control_pin_driven_in ? 0 : flt + int'(flt < 99999);
            if (awake_out && !aw_d) lm <= mode_out;
        end
    end
    a_awake_len: assert property ($fell(awake_out) |-> awk == 12000) else $error("awake span wrong");
    a_load_slot: assert property ($changed(out_code_out) |-> slp >= 1000 && slp <= 1002)
        else $error("code changed outside update slot");
    a_valid_sticky: assert property (!$fell(out_valid_out)) else $error("valid dropped");
    a_valid_late: assert property (out_valid_out |-> up >= SETTLE_CYCLES) else $error("valid early");
    a_ext_spacing: assert property ($rose(awake_out) && mode_out == 2'h2 |-> gap >= 14000)
        else $error("external conversions too close");
    a_float_micro: assert property (flt >= 16000 |-> mode_out == 2'h0) else $error("float not micro");
    a_sleep_gap: assert property ($rose(awake_out) |-> slp >= 1999) else $error("sleep gap short");
    a_rate_period: assert property ($rose(awake_out) && mode_out == lm && mode_out != 2'h2
        |-> gap == (mode_out == 2'h1 ? 16000 : UP_PERIOD_TICKS * 1000)) else $error("rate period wrong");
    c_ext: cover property ($rose(awake_out) && mode_out == 2'h2);
    c_turbo: cover property ($rose(awake_out) && mode_out == 2'h1);
    c_valid: cover property ($rose(out_valid_out));
endmodule : hsms_seq_chk
bind hsms_sequencer hsms_seq_chk #(.SETTLE_CYCLES(SETTLE_CYCLES), .UP_PERIOD_TICKS(UP_PERIOD_TICKS)) chk_u (
    .clk_in(clk_in), .nrst_in(nrst_in), .mode_control_pin_in(mode_control_pin_in),
    .mode_control_pin_driven_in(mode_control_pin_driven_in), .sample_code_in(sample_code_in),
    .out_code_out(out_code_out), .out_valid_out(out_valid_out), .awake_out(awake_out), .mode_out(mode_out));

// [sim/hsms_host_model.sv]
// Purpose: Host driving the mode control pin
// Assumes: cmd 0 float, 1 low, 2 high, 3 one pulse
// Notes:   Floating pin shows junk; the pull-down is the driven flag
`timescale 1ns/1ps
module hsms_host_model (
    input  wire logic       clk_in,
    input  wire logic [1:0] cmd_in,
    output logic            pin_out = 1'b0,
    output logic            drv_out = 1'b1
);
    int hi_cnt = 0; // Cycles into the current pulse
    // Pin update off the sampling edge
    always @(negedge clk_in) begin
        drv_out <= cmd_in != 2'h0;
        if (cmd_in == 2'h0) pin_out <= 1'($urandom);
        else if (cmd_in == 2'h3) begin
            hi_cnt  <= hi_cnt + 1;
            pin_out <= hi_cnt < 4000;
        end else begin
            hi_cnt  <= 0;
            pin_out <= cmd_in == 2'h2;
        end
    end
endmodule : hsms_host_model

// [sim/hsms_sequencer_bench.sv]
// Purpose: Self-checking bench of the sequencer
// Assumes: Settle 50 clocks, micro period 16 ticks
// Notes:   Expected codes come from a queue model
`timescale 1ns/1ps
module hsms_sequencer_bench;
    logic       clk_in = 1'b0, nrst_in = 1'b0, pin, drv, valid, awake;
    logic [1:0] cmd = 2'h1, mode;
    logic [7:0] samp = 8'h00, code;
    int         n_fail = 0, comparisons = 0, n_conv = 0, n;
    logic [7:0] exp_q[$]; // Pending expected codes
    initial forever #5 clk_in = ~clk_in;
    hsms_host_model host_u (.clk_in(clk_in), .cmd_in(cmd), .pin_out(pin), .drv_out(drv));
    hsms_sequencer #(.SETTLE_CYCLES(50), .UP_PERIOD_TICKS(16)) dut_u (.clk_in(clk_in), .nrst_in(nrst_in),
        .mode_control_pin_in(pin), .mode_control_pin_driven_in(drv), .sample_code_in(samp),
        .out_code_out(code), .out_valid_out(valid), .awake_out(awake), .mode_out(mode));
    task automatic chk(input logic [7:0] seen, input logic [7:0] want);
        comparisons++;
        if (seen !== want) begin
            n_fail++;
            $display("mismatch t=%0t seen %h want %h", $time, seen, want);
        end
    endtask : chk
    task automatic close_out;
        $display("counts: %0d mismatches, %0d comparisons", n_fail, comparisons);
        if (n_fail == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : close_out
    task automatic ticks(input int k);
        repeat (k * 1000) @(negedge clk_in);
    endtask : ticks
    // New sample once a conversion is awake; the first one is null field
    always @(posedge awake) begin
        @(negedge clk_in);
        n_conv++;
        samp = (n_conv == 1) ? 8'h00 : 8'($urandom);
    end
    // Model: result is the sample offset to mid code, loaded one tick later
    // The unknown-to-low step of awake at the first reset edge is not a conversion
    always @(negedge awake) begin
        if (nrst_in === 1'b1) begin
            exp_q.push_back(samp ^ 8'h80);
            repeat (1010) @(negedge clk_in);
            chk(code, exp_q.pop_front());
            chk(8'(valid), 8'h01);
        end
    end
    initial begin
        void'($urandom(61633));
        fork begin repeat (125000) @(posedge clk_in); n_fail++; close_out(); end join_none
        repeat (2) @(negedge clk_in);
        nrst_in = 1'b1;
        chk(code, 8'h80);
        chk(8'(valid), 8'h00);
        chk(8'(mode), 8'h00);
        ticks(1);
        $display("test reset done");
        cmd = 2'h3;
        ticks(6);
        cmd = 2'h1;
        repeat (2) @(negedge clk_in);
        cmd = 2'h3; // Edge in mid conversion is ignored
        ticks(9);
        chk(8'(n_conv), 8'h01);
        chk(8'(mode), 8'h02);
        cmd = 2'h1;
        ticks(1);
        cmd = 2'h3;
        ticks(16);
        chk(8'(n_conv), 8'h02);
        $display("test external done");
        cmd = 2'h2;
        ticks(16);
        chk(8'(mode), 8'h01);
        n = n_conv;
        ticks(17);
        chk(8'(n_conv - n > 0), 8'h01);
        $display("test turbo done");
        cmd = 2'h0;
        ticks(16);
        chk(8'(mode), 8'h00);
        n = n_conv;
        ticks(35);
        chk(8'(n_conv - n >= 2), 8'h01);
        $display("test float done");
        close_out();
    end
endmodule : hsms_sequencer_bench
